//--- core/rie_consts.vh
// Constants for the reset and interrupt entry block
`ifndef RIE_CONSTS_VH
`define RIE_CONSTS_VH
// Register indices; byte address on the bus is four times the index
`define RIE_IDX_SYSCTL    20'hee012
`define RIE_IDX_SENSE     20'hee014
`define RIE_IDX_ENABLE    20'hee015
`define RIE_IDX_STATUS    20'hee016
`define RIE_IDX_PRIO_A    20'hee018
`define RIE_IDX_PRIO_B    20'hee019
// Reset values and the status flag mask
`define RIE_SYSCTL_RST    8'h09
`define RIE_REG_RST       8'h00
`define RIE_STATUS_MASK   8'h3f
// Field positions in system_control
`define RIE_USER_SEL_BIT  3
`define RIE_NMI_EDGE_BIT  2
// Vector numbers
`define RIE_VEC_RESET     6'h00
`define RIE_VEC_NMI       6'h07
`define RIE_VEC_TRAP      6'h08
`define RIE_VEC_PIN       6'h0c
`define RIE_VEC_INT       6'h14
// Source counts
`define RIE_NUM_PIN       6
`define RIE_NUM_INT       36
`define RIE_NUM_SRC       42
// Bit of {priority_level_a, priority_level_b} for each pin request
`define RIE_PRIO_PIN0     15
`define RIE_PRIO_PIN1     14
`define RIE_PRIO_PIN23    13
`define RIE_PRIO_PIN45    12
// Internal source groups: first source past each group and its priority bit
`define RIE_GRP0_END      4
`define RIE_GRP1_END      8
`define RIE_GRP2_END      12
`define RIE_GRP3_END      16
`define RIE_GRP4_END      20
`define RIE_GRP5_END      24
`define RIE_GRP6_END      26
`define RIE_GRP7_END      30
`define RIE_GRP8_END      34
`define RIE_GRP0_BIT      11
`define RIE_GRP1_BIT      10
`define RIE_GRP2_BIT      9
`define RIE_GRP3_BIT      8
`define RIE_GRP4_BIT      7
`define RIE_GRP5_BIT      6
`define RIE_GRP6_BIT      5
`define RIE_GRP7_BIT      3
`define RIE_GRP8_BIT      2
`define RIE_GRP9_BIT      1
`endif

//--- core/rie_pin_sync.v
// Two-stage pin synchroniser with a delayed copy for edge detection
`timescale 1ns/10ps
module rie_pin_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rstn,
    // Asynchronous pins and their settled samples
    input  wire [W-1:0] pin_in,
    input  wire [W-1:0] idle_val,
    output reg  [W-1:0] sync_out,
    output reg  [W-1:0] prev_out
);

    reg [W-1:0] meta_reg;

    // Samples are kept relative to idle_val, so a bit reads 1 at its idle level;
    // the constant reset value then means idle for every pin
    // First stage feeds only the second; the third keeps last settled value
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= {W{1'b1}};
            sync_out <= {W{1'b1}};
            prev_out <= {W{1'b1}};
        end else begin
            meta_reg <= pin_in ^ ~idle_val;
            sync_out <= meta_reg;
            prev_out <= sync_out;
        end
    end

endmodule

//--- core/rie_top.v
// Reset entry, interrupt arbitration and exception sequencing
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/10ps
`include "rie_consts.vh"
// Behaviour
// - while the init pin is low, the core is held and nothing proceeds.
// - reset entry starts on the low-to-high change of the init pin, or after a watchdog overflow.
// - watchdog overflow causes the same reset entry as the init pin.
// - reset entry clears core and module state and sets the mask bit.
// - after reset the start address is fetched from vector 0, width by mode.
// - after reset all requests, even nonmaskable, wait for the first instruction.
// - seven external and 36 internal sources, each with its own vector.
// - maskable sources take one of two levels per module; ties arbitrated.
// - the nonmaskable request wins always and ignores the mask bits.
// - watchdog interval overflow raises a request at every overflow.
// - trap with select 0 sets mask and user bit, with select 1 mask only.
// - trap vector number 0 to 3 comes from the instruction code.
// - mask bit and user bit together give three masking levels.
// - each of six request pins picks falling edge or low level.
// - user select bit 3 makes user bit a mask at 0; resets to 1.
// - nonmaskable edge bit 2 picks falling at 0, rising at 1.
// - system control loads 09 on reset and hardware standby only.
// - priority register A is 8-bit; its top bit governs pin request 0.
// - status flags are cleared by writing 0 after reading 1, or on entry in edge mode; writing 1 never sets.
// - entry pushes counter and condition codes before mask and vector fetch.
// - a pending request is taken only at an instruction boundary.
module rie_top (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // Device pins
    input  wire        chip_init_pin_n,
    input  wire        nmi_pin,
    input  wire [5:0]  irq_pin_n,
    input  wire        hw_standby_n,
    input  wire        advanced_mode,
    // Watchdog and peripheral requests
    input  wire        watchdog_reset_ovf,
    input  wire        watchdog_interval_ovf,
    input  wire [35:0] int_req,
    // Core sequencer
    input  wire        insn_boundary,
    input  wire        first_insn_done,
    input  wire        cond_code_mask,
    input  wire        cond_code_user,
    input  wire        trap_req,
    input  wire [1:0]  trap_num,
    input  wire        stack_push_done,
    input  wire        vec_fetch_done,
    output wire        core_hold,
    output wire        module_reset,
    output wire        trap_ack,
    output wire        stack_push_req,
    output wire        set_mask_bit,
    output wire        set_user_bit,
    output wire        vec_fetch_req,
    output reg  [15:0] vec_addr_reg,
    output reg         vec_long_reg,
    output reg  [5:0]  exc_vector_reg,
    // Avalon-MM slave
    input  wire [23:0] avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest
);

    localparam ST_RESET  = 3'd0;
    localparam ST_RFETCH = 3'd1;
    localparam ST_IDLE   = 3'd2;
    localparam ST_PUSH   = 3'd3;
    localparam ST_MASK   = 3'd4;
    localparam ST_FETCH  = 3'd5;

    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [7:0]  system_control_reg;
    reg  [7:0]  request_sense_select_reg;
    reg  [7:0]  request_enable_reg;
    reg  [5:0]  request_status_reg;
    reg  [5:0]  status_seen_reg;
    reg  [7:0]  priority_level_a_reg;
    reg  [7:0]  priority_level_b_reg;
    reg         nmi_flag_reg;
    reg         wd_flag_reg;
    reg         first_block_reg;
    reg         ack_reg;
    reg         trap_taken_reg;
    reg  [5:0]  src_idx_reg;
    reg         src_valid_reg;
    wire [8:0]  pins_sync;
    wire [8:0]  pins_prev;
    wire        init_high;
    wire        nmi_s;
    wire        nmi_p;
    wire [5:0]  irq_s;
    wire [5:0]  irq_p;
    wire        standby_s;
    wire        in_reset;
    wire        bus_req;
    wire        bus_ack;
    wire        wr_en;
    wire        rd_done;
    wire [21:0] reg_idx;
    wire        user_sel;
    wire        nmi_edge;
    wire [15:0] prio_bits;
    wire [41:0] src_pend;
    wire [41:0] src_lvl;
    reg         hi_any;
    reg         lo_any;
    reg  [5:0]  hi_idx;
    reg  [5:0]  lo_idx;
    reg         take_nmi;
    reg         take_src;
    reg  [5:0]  take_idx;
    reg         take_trap;
    reg  [5:0]  take_vec;
    reg  [7:0]  rd_mux;
    reg  [5:0]  clr_by_exc;
    reg  [31:0] int_vec_wide;
    integer     k;

    // Synchronise the init, nonmaskable, standby and request pins (not advanced_mode); init reads inverted, so a reset leaves it asserted
    rie_pin_sync #(.W(9)) u_sync (
        .clk      (clk),
        .rstn     (rstn),
        .pin_in   ({chip_init_pin_n, nmi_pin, hw_standby_n, irq_pin_n}),
        .idle_val (9'h0ff),
        .sync_out (pins_sync),
        .prev_out (pins_prev)
    );
    assign init_high = ~pins_sync[8];
    assign nmi_s     = pins_sync[7];
    assign nmi_p     = pins_prev[7];
    assign standby_s = ~pins_sync[6];
    assign irq_s     = pins_sync[5:0];
    assign irq_p     = pins_prev[5:0];

    // Reset state held by a low init pin or a watchdog overflow
    assign in_reset     = (state_reg == ST_RESET);
    assign core_hold    = in_reset;
    assign module_reset = in_reset;

    // Bus slave: one wait cycle, then the answer
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_reg;
    assign bus_ack         = bus_req & ack_reg;
    assign reg_idx         = avs_address[23:2];
    assign wr_en           = bus_ack & avs_write & avs_byteenable[0];
    assign rd_done         = bus_ack & avs_read;

    // Read data mux; unmapped indices read zero
    always @* begin
        rd_mux = 8'h00;
        case (reg_idx)
            `RIE_IDX_SYSCTL: rd_mux = system_control_reg;
            `RIE_IDX_SENSE:  rd_mux = request_sense_select_reg;
            `RIE_IDX_ENABLE: rd_mux = request_enable_reg;
            `RIE_IDX_STATUS: rd_mux = {2'b00, request_status_reg};
            `RIE_IDX_PRIO_A: rd_mux = priority_level_a_reg;
            `RIE_IDX_PRIO_B: rd_mux = priority_level_b_reg;
            default:         rd_mux = 8'h00;
        endcase
    end

    // Handshake and read data register
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_reg      <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            if (avs_read && !ack_reg)
                avs_readdata <= {24'h000000, rd_mux};
        end
    end

    // Configuration registers, reinitialised by reset and hardware standby
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            system_control_reg       <= `RIE_SYSCTL_RST;
            request_sense_select_reg <= `RIE_REG_RST;
            request_enable_reg       <= `RIE_REG_RST;
            priority_level_a_reg     <= `RIE_REG_RST;
            priority_level_b_reg     <= `RIE_REG_RST;
        end else if (in_reset || standby_s) begin
            system_control_reg       <= `RIE_SYSCTL_RST;
            request_sense_select_reg <= `RIE_REG_RST;
            request_enable_reg       <= `RIE_REG_RST;
            priority_level_a_reg     <= `RIE_REG_RST;
            priority_level_b_reg     <= `RIE_REG_RST;
        end else if (wr_en) begin
            case (reg_idx)
                `RIE_IDX_SYSCTL: system_control_reg       <= avs_writedata[7:0];
                `RIE_IDX_SENSE:  request_sense_select_reg <= avs_writedata[7:0];
                `RIE_IDX_ENABLE: request_enable_reg       <= avs_writedata[7:0];
                `RIE_IDX_PRIO_A: priority_level_a_reg     <= avs_writedata[7:0];
                `RIE_IDX_PRIO_B: priority_level_b_reg     <= avs_writedata[7:0];
                default:         ;
            endcase
        end
    end

    assign user_sel  = system_control_reg[`RIE_USER_SEL_BIT];
    assign nmi_edge  = system_control_reg[`RIE_NMI_EDGE_BIT];
    assign prio_bits = {priority_level_a_reg, priority_level_b_reg};

    // Edge-mode flags of the taken pin request clear on exception entry
    always @* begin
        clr_by_exc = 6'h00;
        if (take_src && (take_idx < `RIE_NUM_PIN))
            clr_by_exc[take_idx[2:0]] = request_sense_select_reg[take_idx[2:0]];
    end

    // Pin request flags: set wins over clears
    genvar g;
    generate
        for (g = 0; g < `RIE_NUM_PIN; g = g + 1) begin : g_pin
            wire set_f = request_sense_select_reg[g] ? (irq_p[g] & ~irq_s[g]) : ~irq_s[g];
            wire clr_w = wr_en && (reg_idx == `RIE_IDX_STATUS) && !avs_writedata[g]
                         && status_seen_reg[g];
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    request_status_reg[g] <= 1'b0;
                    status_seen_reg[g]    <= 1'b0;
                end else if (in_reset || standby_s) begin
                    request_status_reg[g] <= 1'b0;
                    status_seen_reg[g]    <= 1'b0;
                end else begin
                    if (set_f)
                        request_status_reg[g] <= 1'b1;
                    else if (clr_w || clr_by_exc[g])
                        request_status_reg[g] <= 1'b0;
                    if (rd_done && (reg_idx == `RIE_IDX_STATUS))
                        status_seen_reg[g] <= request_status_reg[g];
                    else if (clr_w)
                        status_seen_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Priority bit for each internal source group
    function integer int_grp_bit;
        input integer i;
        begin
            if (i < `RIE_GRP0_END)      int_grp_bit = `RIE_GRP0_BIT;
            else if (i < `RIE_GRP1_END) int_grp_bit = `RIE_GRP1_BIT;
            else if (i < `RIE_GRP2_END) int_grp_bit = `RIE_GRP2_BIT;
            else if (i < `RIE_GRP3_END) int_grp_bit = `RIE_GRP3_BIT;
            else if (i < `RIE_GRP4_END) int_grp_bit = `RIE_GRP4_BIT;
            else if (i < `RIE_GRP5_END) int_grp_bit = `RIE_GRP5_BIT;
            else if (i < `RIE_GRP6_END) int_grp_bit = `RIE_GRP6_BIT;
            else if (i < `RIE_GRP7_END) int_grp_bit = `RIE_GRP7_BIT;
            else if (i < `RIE_GRP8_END) int_grp_bit = `RIE_GRP8_BIT;
            else                        int_grp_bit = `RIE_GRP9_BIT;
        end
    endfunction

    // Pending and level per source; source 6 also carries the watchdog flag
    assign src_pend[5:0] = request_status_reg & request_enable_reg[5:0];
    assign src_lvl[0]    = prio_bits[`RIE_PRIO_PIN0];
    assign src_lvl[1]    = prio_bits[`RIE_PRIO_PIN1];
    assign src_lvl[2]    = prio_bits[`RIE_PRIO_PIN23];
    assign src_lvl[3]    = prio_bits[`RIE_PRIO_PIN23];
    assign src_lvl[4]    = prio_bits[`RIE_PRIO_PIN45];
    assign src_lvl[5]    = prio_bits[`RIE_PRIO_PIN45];
    generate
        for (g = 0; g < `RIE_NUM_INT; g = g + 1) begin : g_int
            if (g == 0) begin : g_wd
                assign src_pend[`RIE_NUM_PIN] = int_req[0] | wd_flag_reg;
            end else begin : g_pl
                assign src_pend[`RIE_NUM_PIN + g] = int_req[g];
            end
            assign src_lvl[`RIE_NUM_PIN + g] = prio_bits[int_grp_bit(g)];
        end
    endgenerate

    // Fixed order within each level: lowest index wins
    always @* begin
        hi_any = 1'b0;
        lo_any = 1'b0;
        hi_idx = 6'h00;
        lo_idx = 6'h00;
        for (k = `RIE_NUM_SRC - 1; k >= 0; k = k - 1) begin
            if (src_pend[k] && src_lvl[k]) begin
                hi_any = 1'b1;
                hi_idx = k[5:0];
            end
            if (src_pend[k] && !src_lvl[k]) begin
                lo_any = 1'b1;
                lo_idx = k[5:0];
            end
        end
    end

    // Acceptance: nonmaskable first, then masked levels, then trap
    always @* begin
        take_nmi  = 1'b0;
        take_src  = 1'b0;
        take_idx  = 6'h00;
        take_trap = 1'b0;
        take_vec  = `RIE_VEC_NMI;
        int_vec_wide = 32'h00000000;
        if (state_reg == ST_IDLE && insn_boundary && !first_block_reg) begin
            if (nmi_flag_reg) begin
                take_nmi = 1'b1;
            end else if (hi_any && (!cond_code_mask ||
                         (!user_sel && !cond_code_user))) begin
                take_src = 1'b1;
                take_idx = hi_idx;
            end else if (lo_any && !cond_code_mask) begin
                take_src = 1'b1;
                take_idx = lo_idx;
            end else if (trap_req) begin
                take_trap = 1'b1;
                take_vec  = `RIE_VEC_TRAP + {4'h0, trap_num};
            end
            if (take_src) begin
                int_vec_wide = `RIE_VEC_INT + take_idx - `RIE_NUM_PIN;
                take_vec = (take_idx < `RIE_NUM_PIN) ? `RIE_VEC_PIN + take_idx : int_vec_wide[5:0];
            end
        end
    end
    assign trap_ack = take_trap;

    // Nonmaskable edge flag and watchdog interval flag; set wins
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nmi_flag_reg <= 1'b0;
            wd_flag_reg  <= 1'b0;
        end else if (in_reset) begin
            nmi_flag_reg <= 1'b0;
            wd_flag_reg  <= 1'b0;
        end else begin
            if (nmi_edge ? (nmi_s & ~nmi_p) : (nmi_p & ~nmi_s))
                nmi_flag_reg <= 1'b1;
            else if (take_nmi)
                nmi_flag_reg <= 1'b0;
            if (watchdog_interval_ovf)
                wd_flag_reg <= 1'b1;
            else if (take_src && take_idx == `RIE_NUM_PIN)
                wd_flag_reg <= 1'b0;
        end
    end

    // Sequencer state transitions
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET:  if (init_high) state_next = ST_RFETCH;
            ST_RFETCH: if (vec_fetch_done) state_next = ST_IDLE;
            ST_IDLE:   if (take_nmi || take_src || take_trap) state_next = ST_PUSH;
            ST_PUSH:   if (stack_push_done) state_next = ST_MASK;
            ST_MASK:   state_next = ST_FETCH;
            ST_FETCH:  if (vec_fetch_done) state_next = ST_IDLE;
            default:   state_next = ST_RESET;
        endcase
        if (!init_high || watchdog_reset_ovf)
            state_next = ST_RESET;
    end

    // State, vector and first-instruction guard registers
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg       <= ST_RESET;
            first_block_reg <= 1'b1;
            trap_taken_reg  <= 1'b0;
            src_idx_reg     <= 6'h00;
            src_valid_reg   <= 1'b0;
            exc_vector_reg  <= `RIE_VEC_RESET;
            vec_addr_reg    <= 16'h0000;
            vec_long_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_next == ST_RESET) begin
                first_block_reg <= 1'b1;
                exc_vector_reg  <= `RIE_VEC_RESET;
                vec_addr_reg    <= 16'h0000;
                vec_long_reg    <= advanced_mode;
            end else if (first_insn_done) begin
                first_block_reg <= 1'b0;
            end
            if (state_reg == ST_IDLE && state_next == ST_PUSH) begin
                trap_taken_reg <= take_trap;
                src_idx_reg    <= take_idx;
                src_valid_reg  <= take_src;
                exc_vector_reg <= take_vec;
                vec_long_reg   <= advanced_mode;
                vec_addr_reg   <= advanced_mode ? {8'h00, take_vec, 2'b00}
                                                : {9'h000, take_vec, 1'b0};
            end
        end
    end

    // Core-facing strobes of the exception sequence
    assign stack_push_req = (state_reg == ST_PUSH);
    assign vec_fetch_req  = (state_reg == ST_RFETCH) || (state_reg == ST_FETCH);
    assign set_mask_bit   = in_reset || (state_reg == ST_MASK);
    assign set_user_bit   = (state_reg == ST_MASK) && !user_sel;

endmodule

//--- tb/rie_core_model.sv
// Core sequencer model answering push and fetch requests
`timescale 1ns/10ps
module rie_core_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Sequencer handshake
    input  wire logic stack_push_req,
    input  wire logic vec_fetch_req,
    output logic      stack_push_done,
    output logic      vec_fetch_done
);
    integer seed = 32'h458d;
    integer pc, fc;
    // Push then fetch, each after a random 0..3 cycle stall
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stack_push_done <= 1'b0;
            vec_fetch_done  <= 1'b0;
            pc = 0;
            fc = 0;
        end else begin
            stack_push_done <= 1'b0;
            vec_fetch_done  <= 1'b0;
            if (stack_push_req && !stack_push_done) begin
                if (pc == 0) begin stack_push_done <= 1'b1; pc = $unsigned($random(seed)) % 4; end
                else pc = pc - 1;
            end
            if (vec_fetch_req && !vec_fetch_done) begin
                if (fc == 0) begin vec_fetch_done <= 1'b1; fc = $unsigned($random(seed)) % 4; end
                else fc = fc - 1;
            end
        end
    end
endmodule

//--- tb/rie_top_asserts.sv
// Checker of the exception sequencing seen at the top ports
`timescale 1ns/10ps
module rie_top_asserts (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Watched ports
    input wire logic        chip_init_pin_n,
    input wire logic        watchdog_reset_ovf,
    input wire logic        insn_boundary,
    input wire logic        trap_ack,
    input wire logic        stack_push_req,
    input wire logic        stack_push_done,
    input wire logic        set_mask_bit,
    input wire logic        core_hold,
    input wire logic        module_reset,
    input wire logic        vec_fetch_req,
    input wire logic [15:0] vec_addr_reg,
    input wire logic        vec_long_reg,
    input wire logic [5:0]  exc_vector_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_init_holds: assert property ($fell(chip_init_pin_n) |-> ##[1:4] core_hold)
        else $error("init low did not hold core");
    a_no_early_start: assert property (core_hold && !chip_init_pin_n |=> core_hold)
        else $error("left reset while init low");
    a_wdt_resets: assert property (watchdog_reset_ovf |=> core_hold)
        else $error("watchdog overflow did not reset");
    a_reset_mask: assert property (core_hold |-> set_mask_bit && module_reset)
        else $error("reset without mask set");
    a_reset_vector: assert property ($rose(vec_fetch_req) && $past(core_hold) |-> vec_addr_reg == 16'h0000)
        else $error("reset vector address wrong");
    a_fetch_addr: assert property (vec_fetch_req |->
        vec_addr_reg == (vec_long_reg ? {8'h00, exc_vector_reg, 2'b00} : {9'h000, exc_vector_reg, 1'b0}))
        else $error("vector address not from vector number");
    a_push_then_mask: assert property (stack_push_req && stack_push_done |=> set_mask_bit && !stack_push_req)
        else $error("mask not set after push");
    a_mask_then_fetch: assert property (set_mask_bit && !core_hold |=> vec_fetch_req)
        else $error("fetch not after mask");
    a_push_stays: assert property (stack_push_req && !stack_push_done |=> stack_push_req)
        else $error("push request dropped early");
    a_take_boundary: assert property (trap_ack |-> insn_boundary ##1 stack_push_req)
        else $error("trap taken off boundary");
    c_trap: cover property (trap_ack);
    c_fetch: cover property ($rose(vec_fetch_req));
    c_wdt: cover property (watchdog_reset_ovf);
endmodule
bind rie_top rie_top_asserts u_chk (.clk(clk), .rstn(rstn), .chip_init_pin_n(chip_init_pin_n),
    .watchdog_reset_ovf(watchdog_reset_ovf), .insn_boundary(insn_boundary), .trap_ack(trap_ack),
    .stack_push_req(stack_push_req), .stack_push_done(stack_push_done), .set_mask_bit(set_mask_bit),
    .core_hold(core_hold), .module_reset(module_reset), .vec_fetch_req(vec_fetch_req),
    .vec_addr_reg(vec_addr_reg), .vec_long_reg(vec_long_reg), .exc_vector_reg(exc_vector_reg));

//--- tb/testbench.sv
// Self-checking bench for the reset and interrupt entry block
`timescale 1ns/10ps
`include "rie_consts.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module testbench;
    logic clk = 0, rstn = 0, init_n = 0, nmi = 1, wdr = 0, fid = 0, msk = 0, trq = 0, adv = 1, rd = 0, wr = 0;
    logic [1:0] tn = 0;
    logic [35:0] irq = 0;
    logic [23:0] adr = 0;
    logic [31:0] wd = 0, rdata;
    logic hold, mrst, tack, preq, pdone, smask, suser, freq, fdone, vlong, wt, useen;
    logic [15:0] vaddr;
    logic [5:0] vnum;
    logic [7:0] q, rnd;
    logic wio = 0;
    integer error_cnt = 0, comparisons = 0, seed = 32'h458d, k;
    int rv[6] = '{8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [19:0] ix[6] = '{`RIE_IDX_SYSCTL, `RIE_IDX_SENSE, `RIE_IDX_ENABLE, `RIE_IDX_STATUS,
                           `RIE_IDX_PRIO_A, `RIE_IDX_PRIO_B};
    rie_top rie_top_i (.clk(clk), .rstn(rstn), .chip_init_pin_n(init_n), .nmi_pin(nmi), .irq_pin_n(6'h3f),
        .hw_standby_n(1'b1), .advanced_mode(adv), .watchdog_reset_ovf(wdr), .watchdog_interval_ovf(wio),
        .int_req(irq), .insn_boundary(1'b1), .first_insn_done(fid), .cond_code_mask(msk), .cond_code_user(1'b0),
        .trap_req(trq), .trap_num(tn), .stack_push_done(pdone), .vec_fetch_done(fdone), .core_hold(hold),
        .module_reset(mrst), .trap_ack(tack), .stack_push_req(preq), .set_mask_bit(smask), .set_user_bit(suser),
        .vec_fetch_req(freq), .vec_addr_reg(vaddr), .vec_long_reg(vlong), .exc_vector_reg(vnum),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
        .avs_readdata(rdata), .avs_waitrequest(wt));
    rie_core_model rie_core_model_i (.clk(clk), .rstn(rstn), .stack_push_req(preq), .vec_fetch_req(freq),
        .stack_push_done(pdone), .vec_fetch_done(fdone));
    // Clock and user bit seen in the mask cycle
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (smask && !hold) useen <= suser;
    task tally_and_finish;
        $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One bus cycle, held until waitrequest is sampled low
    task bus(input logic w, input logic [19:0] i, input logic [7:0] d);
        integer n;
        n = 0;
        @(posedge clk);
        adr <= {2'b00, i, 2'b00}; wr <= w; rd <= !w; wd <= {24'h0, d};
        do begin @(posedge clk); n++; end while (wt !== 1'b0 && n < 50);
        q = rdata[7:0];
        rd <= 0; wr <= 0;
        if (n >= 50) error_cnt++;
    endtask
    // Await a fetch, compare vector and address, then apply the next request set
    task take(input integer ev, input logic [35:0] nxt);
        integer n;
        n = 0;
        while (freq !== 1'b1 && n < 200) begin @(posedge clk); n++; end
        irq <= nxt;
        `CHK(vnum, 6'(ev))
        `CHK(vaddr, 16'(adv ? ev * 4 : ev * 2))
        while (freq === 1'b1 && n < 400) begin @(posedge clk); n++; end
        if (n >= 200) error_cnt++;
    endtask
    initial begin
        #40000;
        error_cnt++;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1;
        repeat (20) @(posedge clk);
        `CHK(hold, 1'b1)
        init_n <= 1;
        take(0, 36'h0);
        for (k = 0; k < 6; k++) begin bus(0, ix[k], 0); `CHK(q, 8'(rv[k])) end
        bus(0, 20'hee013, 0); `CHK(q, 8'h00)
        rnd = 8'($random(seed));
        bus(1, `RIE_IDX_PRIO_A, rnd); bus(0, `RIE_IDX_PRIO_A, 0); `CHK(q, rnd)
        bus(1, `RIE_IDX_PRIO_A, 0);
        bus(1, `RIE_IDX_STATUS, 8'hff); bus(0, `RIE_IDX_STATUS, 0); `CHK(q, 8'h00)
        irq <= 36'h1;
        repeat (10) @(posedge clk);
        `CHK(preq, 1'b0)
        fid <= 1; @(posedge clk); fid <= 0;
        take(20, 36'h0);
        bus(1, `RIE_IDX_PRIO_B, 8'h80);
        irq <= 36'h1_0001;
        take(36, 36'h1);
        take(20, 36'h0);
        msk <= 1; irq <= 36'h1_0001;
        repeat (10) @(posedge clk);
        `CHK(preq, 1'b0)
        nmi <= 0;
        take(7, 36'h1_0001);
        bus(1, `RIE_IDX_SYSCTL, 8'h01);
        take(36, 36'h0);
        msk <= 0;
        for (k = 0; k < 4; k++) begin
            bus(1, `RIE_IDX_SYSCTL, (k % 2) ? 8'h09 : 8'h01);
            adv <= k[0]; tn <= k[1:0]; trq <= 1;
            do @(posedge clk); while (tack !== 1'b1);
            trq <= 0;
            take(8 + k, 36'h0);
            `CHK(useen, !k[0])
        end
        wio <= 1; @(posedge clk); wio <= 0;
        take(20, 36'h0);
        init_n <= 0;
        repeat (12) @(posedge clk);
        `CHK(hold, 1'b1)
        init_n <= 1;
        take(0, 36'h0);
        wdr <= 1; @(posedge clk); wdr <= 0; @(posedge clk);
        `CHK(hold, 1'b1)
        take(0, 36'h0);
        bus(0, `RIE_IDX_PRIO_B, 0); `CHK(q, 8'h00)
        tally_and_finish;
    end
endmodule
